// ===== core/sbcsm_defines.svh
// timing, field and reset constants of the bank command state machine
`ifndef SBCSM_DEFINES_SVH
`define SBCSM_DEFINES_SVH

`define SBCSM_CLK_MHZ 100
`define SBCSM_NBANK 2
`define SBCSM_ADDR_W 12
`define SBCSM_ROW_W 11
`define SBCSM_COL_W 8
`define SBCSM_DQ_W 16
`define SBCSM_TMR_W 4

`define SBCSM_BANK_BIT 11
`define SBCSM_AP_BIT 10
`define SBCSM_MODE_W 7
`define SBCSM_MODE_BT_BIT 3
`define SBCSM_MODE_CL_LSB 4
`define SBCSM_MODE_RST 7'h20
`define SBCSM_CL3 3'h3

`define SBCSM_TRP_NS 20
`define SBCSM_TDPL_NS 20
`define SBCSM_TRC_NS 70
`define SBCSM_NS2CYC(ns) ((((ns) * `SBCSM_CLK_MHZ) + 999) / 1000)
`define SBCSM_TRP_CYC `SBCSM_NS2CYC(`SBCSM_TRP_NS)
`define SBCSM_TDPL_CYC `SBCSM_NS2CYC(`SBCSM_TDPL_NS)
`define SBCSM_TDAL_CYC (`SBCSM_TDPL_CYC + `SBCSM_TRP_CYC)
`define SBCSM_TRC_CYC `SBCSM_NS2CYC(`SBCSM_TRC_NS)

`endif

// ===== core/sbcsm_pkg.sv
// types shared by the bank command state machine
`include "sbcsm_defines.svh"
package sbcsm_pkg;
	typedef enum logic [3:0] {
		ST_IDLE, ST_ACTIVE, ST_READ, ST_READ_AP, ST_WRITE, ST_WRITE_AP,
		ST_WREC, ST_WREC_AP, ST_PRECH, ST_REFRESH
	} sbcsm_state_e;
	typedef enum logic [3:0] {
		CMD_DEVICE_DESELECT_CMD, CMD_NOP, CMD_BST, CMD_READ, CMD_WRITE,
		CMD_ACT, CMD_PRE, CMD_REF, CMD_MRS
	} sbcsm_cmd_e;
	typedef logic [`SBCSM_ROW_W-1:0] sbcsm_row_t;
	typedef logic [`SBCSM_COL_W-1:0] sbcsm_col_t;
	typedef logic [`SBCSM_TMR_W-1:0] sbcsm_timer_t;
	typedef logic [`SBCSM_DQ_W-1:0] sbcsm_data_t;
endpackage

// ===== core/sbcsm_sync.sv
// two-flop synchroniser for the pin inputs
`timescale 1ns/1ns
module sbcsm_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic [WIDTH-1:0] i_d,
	output logic      [WIDTH-1:0] o_q
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= i_d;
			sync_q <= meta_q;
		end
	end

	assign o_q = sync_q;
endmodule

// ===== core/sbcsm_fifo2.sv
// small valid/ready buffer in flip-flops
`timescale 1ns/1ns
module sbcsm_fifo2 #(
	parameter int WIDTH = 20,
	parameter int DEPTH = 2
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	// fill side
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	// drain side
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_ptr_q;
	logic [AW-1:0]    rd_ptr_q;
	logic [AW:0]      count_q;
	logic             push;
	logic             pop;

	assign o_in_ready  = count_q != (AW+1)'(DEPTH);
	assign o_out_valid = count_q != '0;
	assign o_out_data  = mem_q[rd_ptr_q];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			if (push) begin
				mem_q[wr_ptr_q] <= i_in_data;
				wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr_q + 1'b1);
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr_q + 1'b1);
			end
			if (push && !pop) begin
				count_q <= (AW+1)'(count_q + 1'b1);
			end else if (pop && !push) begin
				count_q <= (AW+1)'(count_q - 1'b1);
			end
		end
	end
endmodule

// ===== core/sbcsm_top.sv
// two-bank synchronous dram command state machine with burst engine
// Summary of operation
// RULE_01: idle ignores deselect, no-op, burst stop
// RULE_02: read burst runs out, then row active
// RULE_03: burst stop ends read, row active
// RULE_04: new read restarts read at new column
// RULE_05: write during read starts write burst
// RULE_06: precharge cuts read, bank precharges
// RULE_07: write burst runs out, then recovery
// RULE_08: burst stop ends write, row active
// RULE_09: read during write starts read burst
// RULE_10: new write restarts write at column
// RULE_11: precharge cuts write, bank precharges
// RULE_12: read autoprecharge finishes, then precharges
// RULE_13: idle activate, refresh, mode set; active bursts
// RULE_14: controller avoids illegal command combinations
// RULE_15: read data stops latency after stop
// RULE_16: write autoprecharge finishes, recovery, precharge
// RULE_17: precharged bank idles after precharge time
`timescale 1ns/1ns
`include "sbcsm_defines.svh"
module sbcsm_top
	import sbcsm_pkg::*;
(
	// clock and reset
	input  wire logic                     I_CLK_SYS,
	input  wire logic                     I_RST,
	// command pins
	input  wire logic                     I_CS_N,
	input  wire logic                     I_RAS_N,
	input  wire logic                     I_CAS_N,
	input  wire logic                     I_WE_N,
	input  wire logic                     I_CKE,
	input  wire logic [`SBCSM_ADDR_W-1:0] I_ADDR,
	input  wire logic [`SBCSM_DQ_W-1:0]   I_DQ,
	// read beat stream
	input  wire logic                     I_RD_READY,
	output logic                          O_RD_VALID,
	output logic                          O_RD_BANK,
	output sbcsm_row_t                    O_RD_ROW,
	output sbcsm_col_t                    O_RD_COL,
	// write beat strobe
	output logic                          O_WR_EN,
	output logic                          O_WR_BANK,
	output sbcsm_row_t                    O_WR_ROW,
	output sbcsm_col_t                    O_WR_COL,
	output sbcsm_data_t                   O_WR_DATA,
	// status
	output sbcsm_state_e                  O_BANK0_STATE,
	output sbcsm_state_e                  O_BANK1_STATE,
	output logic [`SBCSM_MODE_W-1:0]      O_MODE,
	output logic                          O_ILLEGAL_CMD,
	output logic                          O_POWER_DOWN,
	output logic                          O_SELF_REFRESH
);
	localparam int NB    = `SBCSM_NBANK;
	localparam int PIN_W = 5 + `SBCSM_ADDR_W + `SBCSM_DQ_W;
	localparam int BEAT_W = 1 + `SBCSM_ROW_W + `SBCSM_COL_W;

	function automatic sbcsm_cmd_e decode_cmd(input logic [3:0] pins);
		sbcsm_cmd_e c;
		c = CMD_DEVICE_DESELECT_CMD;
		if (!pins[3]) begin
			case (pins[2:0])
				3'h7: c = CMD_NOP;
				3'h6: c = CMD_BST;
				3'h5: c = CMD_READ;
				3'h4: c = CMD_WRITE;
				3'h3: c = CMD_ACT;
				3'h2: c = CMD_PRE;
				3'h1: c = CMD_REF;
				3'h0: c = CMD_MRS;
			endcase
		end
		return c;
	endfunction

	function automatic sbcsm_state_e done_state(input sbcsm_state_e s);
		sbcsm_state_e r;
		r = ST_ACTIVE;
		if (s == ST_READ_AP) r = ST_PRECH;
		if (s == ST_WRITE) r = ST_WREC;
		if (s == ST_WRITE_AP) r = ST_WREC_AP;
		return r;
	endfunction

	function automatic sbcsm_timer_t timer_load(input sbcsm_state_e s);
		sbcsm_timer_t t;
		t = '0;
		if (s == ST_PRECH) t = sbcsm_timer_t'(`SBCSM_TRP_CYC - 1);
		if (s == ST_WREC) t = sbcsm_timer_t'(`SBCSM_TDPL_CYC - 1);
		if (s == ST_WREC_AP) t = sbcsm_timer_t'(`SBCSM_TDAL_CYC - 1);
		if (s == ST_REFRESH) t = sbcsm_timer_t'(`SBCSM_TRC_CYC - 1);
		return t;
	endfunction

	function automatic logic [8:0] burst_len(input logic [2:0] code);
		logic [8:0] n;
		case (code)
			3'h0: n = 9'h001;
			3'h1: n = 9'h002;
			3'h2: n = 9'h004;
			3'h3: n = 9'h008;
			default: n = 9'h100;
		endcase
		return n;
	endfunction

	// pin capture
	logic [PIN_W-1:0]          pin_raw;
	logic [PIN_W-1:0]          pin_s;
	logic [3:0]                cmd_pins;
	logic                      cke_s;
	logic [`SBCSM_ADDR_W-1:0]  addr_s;
	sbcsm_data_t               dq_s;

	assign pin_raw = {I_CS_N, I_RAS_N, I_CAS_N, I_WE_N, I_CKE, I_ADDR, I_DQ};

	sbcsm_sync #(
		.WIDTH (PIN_W)
	) u_sync (
		.i_clk (I_CLK_SYS),
		.i_rst (I_RST),
		.i_d   (pin_raw),
		.o_q   (pin_s)
	);

	assign {cmd_pins, cke_s, addr_s, dq_s} = pin_s;

	// global state
	logic                      cke_prev_q;
	logic [`SBCSM_MODE_W-1:0]  mode_q;
	logic                      self_q;
	logic                      pdown_q;
	logic                      illegal_q;
	sbcsm_state_e              st_v [NB];
	sbcsm_row_t                row_v [NB];
	logic [NB-1:0]             idle_v;
	logic [NB-1:0]             ap_v;
	logic [NB-1:0]             bok_v;
	logic [NB-1:0]             ill_v;

	// command decode; clock enable low at n-1 masks the command
	sbcsm_cmd_e                cmd;
	logic                      suspend;
	logic                      cmd_bank;
	logic                      cmd_ap;
	logic                      is_rd;
	logic                      is_wr;
	logic                      is_rm;
	logic                      all_idle;
	logic                      ap_busy;
	logic                      start;
	logic                      stop;
	sbcsm_state_e              start_st;

	assign cmd      = cke_prev_q ? decode_cmd(cmd_pins) : CMD_DEVICE_DESELECT_CMD;
	assign suspend  = ~cke_prev_q;
	assign cmd_bank = addr_s[`SBCSM_BANK_BIT];
	assign cmd_ap   = addr_s[`SBCSM_AP_BIT];
	assign is_rd    = cmd == CMD_READ;
	assign is_wr    = cmd == CMD_WRITE;
	assign is_rm    = (cmd == CMD_REF) | (cmd == CMD_MRS);
	assign all_idle = &idle_v;
	assign ap_busy  = |ap_v;

	// burst engine, one burst on the data bus at a time
	logic                      bur_act_q;
	logic                      bur_wr_q;
	logic                      bur_bank_q;
	sbcsm_col_t                bur_base_q;
	sbcsm_col_t                bur_cnt_q;
	logic [8:0]                bur_left_q;
	logic                      e_act;
	logic                      e_wr;
	logic                      e_bank;
	sbcsm_col_t                e_base;
	sbcsm_col_t                e_cnt;
	logic [8:0]                e_left;
	sbcsm_col_t                e_mask;
	sbcsm_col_t                e_off;
	sbcsm_col_t                beat_col;
	logic                      full_page;
	logic                      stall;
	logic                      issue;
	logic                      last;

	assign start = (is_rd | is_wr) & bok_v[cmd_bank] & ~ap_busy; // RULE_04 RULE_05 RULE_09 RULE_10
	assign stop  = bur_act_q & ~ap_busy &
		((cmd == CMD_BST) | ((cmd == CMD_PRE) & (cmd_ap | (cmd_bank == bur_bank_q)))); // RULE_03 RULE_06 RULE_08 RULE_11
	assign start_st = done_state(ST_READ);

	assign e_act     = start | (bur_act_q & ~stop);
	assign e_wr      = start ? is_wr : bur_wr_q;
	assign e_bank    = start ? cmd_bank : bur_bank_q;
	assign e_base    = start ? addr_s[`SBCSM_COL_W-1:0] : bur_base_q;
	assign e_cnt     = start ? '0 : bur_cnt_q;
	assign e_left    = start ? burst_len(mode_q[2:0]) : bur_left_q;
	assign full_page = mode_q[2:0] == 3'h7;
	assign e_mask    = full_page ? 8'hff : sbcsm_col_t'(burst_len(mode_q[2:0]) - 9'h001);
	assign e_off     = mode_q[`SBCSM_MODE_BT_BIT] ? (e_base ^ e_cnt)
		: sbcsm_col_t'(e_base + e_cnt);
	assign beat_col  = (e_base & ~e_mask) | (e_off & e_mask);
	assign issue     = e_act & ~suspend & ~(~e_wr & stall);
	assign last      = issue & ~full_page & (e_left == 9'h001); // RULE_02 RULE_07 RULE_12 RULE_16

	// read latency pipe; a cut burst stops feeding it, so data ceases after the latency
	logic [1:0]                pipe_v_q;
	logic [BEAT_W-1:0]         pipe_p_q [2];
	logic                      cl3;
	logic                      pipe_out_v;
	logic [BEAT_W-1:0]         pipe_out_p;
	logic                      fifo_in_ready;
	logic [BEAT_W-1:0]         rd_beat;

	assign cl3        = mode_q[`SBCSM_MODE_CL_LSB +: 3] == `SBCSM_CL3;
	assign pipe_out_v = cl3 ? pipe_v_q[1] : pipe_v_q[0]; // RULE_15
	assign pipe_out_p = cl3 ? pipe_p_q[1] : pipe_p_q[0];
	assign stall      = pipe_out_v & ~fifo_in_ready;

	sbcsm_fifo2 #(
		.WIDTH (BEAT_W),
		.DEPTH (2)
	) u_fifo (
		.i_clk       (I_CLK_SYS),
		.i_rst       (I_RST),
		.i_in_valid  (pipe_out_v & ~suspend),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (pipe_out_p),
		.o_out_valid (O_RD_VALID),
		.i_out_ready (I_RD_READY),
		.o_out_data  (rd_beat)
	);

	assign {O_RD_BANK, O_RD_ROW, O_RD_COL} = rd_beat;

	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			pipe_v_q    <= '0;
			pipe_p_q[0] <= '0;
			pipe_p_q[1] <= '0;
		end else if (!stall && !suspend) begin
			pipe_v_q    <= {pipe_v_q[0], issue & ~e_wr};
			pipe_p_q[0] <= {e_bank, row_v[e_bank], beat_col};
			pipe_p_q[1] <= pipe_p_q[0];
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			bur_act_q  <= 1'b0;
			bur_wr_q   <= 1'b0;
			bur_bank_q <= 1'b0;
			bur_base_q <= '0;
			bur_cnt_q  <= '0;
			bur_left_q <= '0;
		end else if (!suspend) begin
			bur_act_q  <= e_act & ~last;
			bur_wr_q   <= e_wr;
			bur_bank_q <= e_bank;
			bur_base_q <= e_base;
			bur_cnt_q  <= issue ? sbcsm_col_t'(e_cnt + 8'h01) : e_cnt;
			bur_left_q <= issue ? 9'(e_left - 9'h001) : e_left;
		end
	end

	// write beats carry the data sampled in their own beat cycle
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			O_WR_EN   <= 1'b0;
			O_WR_BANK <= 1'b0;
			O_WR_ROW  <= '0;
			O_WR_COL  <= '0;
			O_WR_DATA <= '0;
		end else begin
			O_WR_EN   <= issue & e_wr;
			O_WR_BANK <= e_bank;
			O_WR_ROW  <= row_v[e_bank];
			O_WR_COL  <= beat_col;
			O_WR_DATA <= dq_s;
		end
	end

	// per-bank state machines
	for (genvar b = 0; b < NB; b++) begin : g_bank
		sbcsm_state_e  st_q;
		sbcsm_state_e  st_d;
		sbcsm_state_e  burst_st;
		sbcsm_timer_t  tmr_q;
		sbcsm_timer_t  tmr_d;
		sbcsm_row_t    row_q;
		logic          hit;
		logic          pre_hit;
		logic          mine_done;
		logic          ill;

		assign hit       = cmd_bank == 1'(b);
		assign pre_hit   = (cmd == CMD_PRE) & (cmd_ap | hit);
		assign mine_done = last & (e_bank == 1'(b));
		assign burst_st  = is_wr ? (cmd_ap ? ST_WRITE_AP : ST_WRITE)
			: (cmd_ap ? ST_READ_AP : ST_READ);
		assign idle_v[b] = st_q == ST_IDLE;
		assign ap_v[b]   = (st_q == ST_READ_AP) | (st_q == ST_WRITE_AP);
		assign bok_v[b]  = (st_q == ST_ACTIVE) | (st_q == ST_READ) | (st_q == ST_WRITE)
			| (st_q == ST_WREC);
		assign ill_v[b]  = ill;
		assign st_v[b]   = st_q;
		assign row_v[b]  = row_q;

		always_comb begin
			st_d = st_q;
			ill  = 1'b0;
			unique case (st_q)
				ST_IDLE: begin
					if (cmd == CMD_ACT && hit) begin
						st_d = ST_ACTIVE; // RULE_13
					end else if (cmd == CMD_REF && all_idle) begin
						st_d = ST_REFRESH; // RULE_13
					end else begin
						ill = ((is_rd | is_wr) & hit) | (is_rm & ~all_idle); // RULE_01 RULE_14
					end
				end
				ST_ACTIVE, ST_WREC: begin
					if (start && hit) begin
						st_d = mine_done ? done_state(burst_st) : burst_st; // RULE_13
					end else if (st_q == ST_WREC && tmr_q == '0) begin
						st_d = ST_ACTIVE;
					end else if (st_q == ST_ACTIVE && pre_hit) begin
						st_d = ST_PRECH; // RULE_13
					end else begin
						ill = ((cmd == CMD_ACT) & hit) | is_rm
							| ((st_q == ST_WREC) & pre_hit); // RULE_14
					end
				end
				ST_READ, ST_WRITE: begin
					if (start && hit) begin
						st_d = mine_done ? done_state(burst_st) : burst_st; // RULE_04 RULE_05 RULE_09 RULE_10
					end else if (start) begin
						st_d = (st_q == ST_WRITE) ? ST_WREC : start_st;
					end else if (pre_hit) begin
						st_d = ST_PRECH; // RULE_06 RULE_11
					end else if (cmd == CMD_BST) begin
						st_d = ST_ACTIVE; // RULE_03 RULE_08
					end else if (mine_done) begin
						st_d = done_state(st_q); // RULE_02 RULE_07
					end else begin
						ill = ((cmd == CMD_ACT) & hit) | is_rm; // RULE_14
					end
				end
				ST_READ_AP, ST_WRITE_AP: begin
					if (mine_done) begin
						st_d = done_state(st_q); // RULE_12 RULE_16
					end
					ill = (cmd != CMD_DEVICE_DESELECT_CMD) & (cmd != CMD_NOP); // RULE_14
				end
				ST_PRECH, ST_WREC_AP: begin
					if (tmr_q == '0) begin
						st_d = ST_IDLE; // RULE_16 RULE_17
					end
					ill = ((is_rd | is_wr | (cmd == CMD_ACT)) & hit) | is_rm;
				end
				ST_REFRESH: begin
					if (!self_q && tmr_q == '0) begin
						st_d = ST_IDLE;
					end
					ill = (cmd != CMD_DEVICE_DESELECT_CMD) & (cmd != CMD_NOP) & (cmd != CMD_BST);
				end
				default: begin
					st_d = ST_IDLE;
				end
			endcase
		end

		// timers reload on every state change and reload every cycle while self refreshing
		assign tmr_d = (st_d != st_q || self_q) ? timer_load(st_d)
			: ((tmr_q != '0) ? sbcsm_timer_t'(tmr_q - 4'h1) : tmr_q); // RULE_17

		always_ff @(posedge I_CLK_SYS) begin
			if (I_RST) begin
				st_q  <= ST_IDLE;
				tmr_q <= '0;
				row_q <= '0;
			end else if (!suspend) begin
				st_q  <= st_d;
				tmr_q <= tmr_d;
				if (st_q == ST_IDLE && cmd == CMD_ACT && hit) begin
					row_q <= addr_s[`SBCSM_ROW_W-1:0];
				end
			end
		end
	end

	// mode, refresh and power state
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			cke_prev_q <= 1'b0;
			mode_q     <= `SBCSM_MODE_RST;
			self_q     <= 1'b0;
			pdown_q    <= 1'b0;
			illegal_q  <= 1'b0;
		end else begin
			cke_prev_q <= cke_s;
			if (cmd == CMD_MRS && all_idle) begin
				mode_q <= addr_s[`SBCSM_MODE_W-1:0]; // RULE_13
			end
			if (!self_q && cmd == CMD_REF && all_idle && !cke_s) begin
				self_q <= 1'b1; // RULE_13
			end else if (self_q && cke_s) begin
				self_q <= 1'b0;
			end
			pdown_q   <= all_idle & ~cke_s & ~self_q; // RULE_01
			illegal_q <= |ill_v;
		end
	end

	assign O_BANK0_STATE  = st_v[0];
	assign O_BANK1_STATE  = st_v[1];
	assign O_MODE         = mode_q;
	assign O_ILLEGAL_CMD  = illegal_q;
	assign O_POWER_DOWN   = pdown_q;
	assign O_SELF_REFRESH = self_q;
endmodule

// ===== tb/sbcsm_properties.sv
// assertions on the ports of the bank command state machine
`timescale 1ns/1ns
`include "sbcsm_defines.svh"
module sbcsm_checker
	import sbcsm_pkg::*;
(
	// clock, reset and pins
	input wire logic                     I_CLK_SYS,
	input wire logic                     I_RST,
	input wire logic                     I_CS_N,
	input wire logic                     I_RAS_N,
	input wire logic                     I_CAS_N,
	input wire logic                     I_WE_N,
	input wire logic                     I_CKE,
	input wire logic [`SBCSM_ADDR_W-1:0] I_ADDR,
	input wire logic [`SBCSM_DQ_W-1:0]   I_DQ,
	// outputs watched
	input wire logic                     I_RD_READY,
	input wire logic                     O_RD_VALID,
	input wire sbcsm_col_t               O_RD_COL,
	input wire logic                     O_WR_EN,
	input wire sbcsm_col_t               O_WR_COL,
	input wire sbcsm_data_t              O_WR_DATA,
	input wire sbcsm_state_e             O_BANK0_STATE
);
	logic [32:0] p1_q;
	logic [32:0] p2_q;
	logic [32:0] p3_q;
	// mirror of the pin synchroniser
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			p1_q <= 33'h0;
			p2_q <= 33'h0;
			p3_q <= 33'h0;
		end else begin
			p1_q <= {I_CKE, I_CS_N, I_RAS_N, I_CAS_N, I_WE_N, I_ADDR, I_DQ};
			p2_q <= p1_q;
			p3_q <= p2_q;
		end
	end
	wire [3:0] c   = p2_q[31:28];
	wire       ok  = p2_q[32] & p3_q[32];
	wire       b0  = ~p2_q[27];
	wire       no_op_cmd = c[3] | (c == 4'h7);
	wire       burst_stop_cmd = ok & (c == 4'h6);
	wire       rd  = ok & b0 & (c == 4'h5);
	wire       wr  = ok & b0 & (c == 4'h4);
	wire       act = ok & b0 & (c == 4'h3);
	wire       pre = ok & (c == 4'h2) & (p2_q[26] | b0);
	sbcsm_state_e st;
	assign st = O_BANK0_STATE;
	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (I_RST);
	sequence s_wr_cmd;
		st == ST_ACTIVE && wr;
	endsequence
	sequence s_wr_beat;
		O_WR_EN && O_WR_COL == $past(p2_q[23:16]) && O_WR_DATA == $past(p2_q[15:0]);
	endsequence
	sequence s_prech_entry;
		st == ST_PRECH && $past(st) != ST_PRECH;
	endsequence
	chk_idle_stays: assert property ((st == ST_IDLE && (no_op_cmd || burst_stop_cmd)) |=> st == ST_IDLE)
		else $error("idle bank left idle on no-op");
	chk_act_opens: assert property (st == ST_IDLE && act |=> st == ST_ACTIVE)
		else $error("activate did not open row");
	chk_rd_runout: assert property (st == ST_READ && no_op_cmd |=> st inside {ST_READ, ST_ACTIVE})
		else $error("read burst left to wrong state");
	chk_bst_read: assert property (st == ST_READ && burst_stop_cmd |=> st == ST_ACTIVE)
		else $error("burst stop in read not active");
	chk_rd_restart: assert property (st == ST_READ && rd |=> st inside {ST_READ, ST_READ_AP})
		else $error("read restart lost");
	chk_wr_in_read: assert property (st == ST_READ && wr |=> st inside {ST_WRITE, ST_WRITE_AP})
		else $error("write in read not started");
	chk_pre_cut: assert property (st inside {ST_READ, ST_WRITE} && pre |=> st == ST_PRECH)
		else $error("precharge did not cut burst");
	chk_wr_runout: assert property (st == ST_WRITE && no_op_cmd |=> st inside {ST_WRITE, ST_WREC})
		else $error("write burst skipped recovery");
	chk_rd_in_write: assert property (st == ST_WRITE && rd |=> st inside {ST_READ, ST_READ_AP})
		else $error("read in write not started");
	chk_wr_first: assert property (s_wr_cmd |=> s_wr_beat)
		else $error("first write beat wrong");
	chk_rda_finish: assert property (st == ST_READ_AP && no_op_cmd |=> st inside {ST_READ_AP, ST_PRECH})
		else $error("read autoprecharge did not precharge");
	chk_prech_idle: assert property (s_prech_entry |-> ##[1:3] st == ST_IDLE)
		else $error("precharged bank not idle in time");
	chk_rd_hold: assert property (O_RD_VALID && !I_RD_READY |=> O_RD_VALID && $stable(O_RD_COL))
		else $error("stalled read beat changed");
endmodule

bind sbcsm_top sbcsm_checker i_sbcsm_checker (.I_CLK_SYS, .I_RST, .I_CS_N, .I_RAS_N, .I_CAS_N,
	.I_WE_N, .I_CKE, .I_ADDR, .I_DQ, .I_RD_READY, .O_RD_VALID, .O_RD_COL, .O_WR_EN, .O_WR_COL,
	.O_WR_DATA, .O_BANK0_STATE);

// ===== tb/sbcsm_ctrl_model.sv
// memory controller model: command pins and read beat consumer
`timescale 1ns/1ns
module sbcsm_ctrl_model (
	// clock and stall request
	input  wire logic   i_clk,
	input  wire logic   i_slow,
	// pins toward the device
	output logic        o_cke,
	output logic [3:0]  o_cmd,
	output logic [11:0] o_addr,
	output logic [15:0] o_dq,
	// read stream
	output logic        o_rd_ready
);
	logic [1:0] cnt_q = 2'h0;
	initial begin
		o_cke = 1'b1;
		o_cmd = 4'hf;
		o_addr = 12'h0;
		o_dq = 16'h0;
		o_rd_ready = 1'b1;
	end
	// one command, then no-ops with inverted address and counting data
	task issue(input logic [3:0] k, input logic [11:0] a, input logic [15:0] d, input int gap);
		int i;
		@(posedge i_clk);
		o_cmd <= k;
		o_addr <= a;
		o_dq <= d;
		for (i = 1; i <= gap; i++) begin
			@(posedge i_clk);
			o_cmd <= 4'h7;
			o_addr <= ~a;
			o_dq <= d + i[15:0];
		end
	endtask
	task set_cke(input logic b);
		@(posedge i_clk);
		o_cke <= b;
	endtask
	always @(posedge i_clk) begin
		cnt_q <= cnt_q + 2'h1;
		o_rd_ready <= !i_slow || cnt_q == 2'h3;
	end
endmodule

// ===== tb/tb_top.sv
// self-checking bench of the bank command state machine
`timescale 1ns/1ns
module tb_top
	import sbcsm_pkg::*;
;
	localparam logic [3:0] NO_OP_CMD = 4'h7, RD = 4'h5, WR = 4'h4, ACT = 4'h3, PRE = 4'h2;
	logic clk;
	logic rst = 1'b1;
	logic slow = 1'b0;
	logic cke, rd_ready, rd_valid, wr_en, ill, pd;
	logic [3:0] cmd;
	logic [11:0] addr;
	logic [15:0] dq;
	sbcsm_col_t rd_col, wr_col;
	sbcsm_data_t wr_data;
	sbcsm_state_e b0, b1;
	logic [6:0] mode;
	logic [7:0] rd_q[$];
	logic [23:0] wr_q[$];
	int err_count = 0;
	int checked = 0;
	int ill_n = 0;
	sbcsm_ctrl_model m (.i_clk(clk), .i_slow(slow), .o_cke(cke), .o_cmd(cmd), .o_addr(addr),
		.o_dq(dq), .o_rd_ready(rd_ready));
	sbcsm_top i_sbcsm_top (.I_CLK_SYS(clk), .I_RST(rst), .I_CS_N(cmd[3]), .I_RAS_N(cmd[2]),
		.I_CAS_N(cmd[1]), .I_WE_N(cmd[0]), .I_CKE(cke), .I_ADDR(addr), .I_DQ(dq),
		.I_RD_READY(rd_ready), .O_RD_VALID(rd_valid), .O_RD_BANK(), .O_RD_ROW(),
		.O_RD_COL(rd_col), .O_WR_EN(wr_en), .O_WR_BANK(), .O_WR_ROW(), .O_WR_COL(wr_col),
		.O_WR_DATA(wr_data), .O_BANK0_STATE(b0), .O_BANK1_STATE(b1), .O_MODE(mode),
		.O_ILLEGAL_CMD(ill), .O_POWER_DOWN(pd), .O_SELF_REFRESH());
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (rd_valid && rd_ready) rd_q.push_back(rd_col);
		if (wr_en) wr_q.push_back({wr_col, wr_data});
		if (ill) ill_n++;
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task wst(input sbcsm_state_e s);
		int k;
		@(negedge clk);
		for (k = 0; k < 30 && b0 !== s; k++) @(negedge clk);
		chk("bank0 state", 32'(s), 32'(b0));
	endtask
	task rdq(input logic [7:0] e[$]);
		int k;
		repeat (24) @(negedge clk);
		chk("read beats", e.size(), rd_q.size());
		for (k = 0; k < e.size() && k < rd_q.size(); k++) chk("read col", e[k], rd_q[k]);
		rd_q.delete();
	endtask
	task wrq(input logic [23:0] e[$]);
		int k;
		repeat (4) @(negedge clk);
		chk("write beats", e.size(), wr_q.size());
		for (k = 0; k < e.size() && k < wr_q.size(); k++) chk("write beat", e[k], wr_q[k]);
		wr_q.delete();
	endtask
	task t_idle();
		m.issue(NO_OP_CMD, 12'h0, 16'h0, 1);
		m.issue(4'hf, 12'h0, 16'h0, 1);
		m.issue(4'h6, 12'h0, 16'h0, 4);
		chk("idle banks", 8'h00, {b0, b1});
		m.issue(RD, 12'h0, 16'h0, 5);
		chk("illegal pulses", 1, ill_n);
		chk("idle after read", 8'h00, {b0, b1});
		m.set_cke(1'b0);
		repeat (6) @(negedge clk);
		chk("power down", 1, pd);
		m.set_cke(1'b1);
		repeat (6) @(negedge clk);
		m.issue(4'h0, 12'h022, 16'h0, 4);
		chk("mode", 7'h22, mode);
		m.issue(4'h1, 12'h0, 16'h0, 1);
		wst(ST_REFRESH);
		wst(ST_IDLE);
	endtask
	task t_read();
		m.issue(ACT, 12'h005, 16'h0, 2);
		wst(ST_ACTIVE);
		m.issue(RD, 12'h004, 16'h0, 8);
		wst(ST_ACTIVE);
		rdq('{8'h04, 8'h05, 8'h06, 8'h07});
		m.issue(RD, 12'h008, 16'h0, 1);
		m.issue(4'h6, 12'h0, 16'h0, 2);
		wst(ST_ACTIVE);
		rdq('{8'h08, 8'h09});
		m.issue(RD, 12'h010, 16'h0, 1);
		m.issue(RD, 12'h020, 16'h0, 6);
		rdq('{8'h10, 8'h11, 8'h20, 8'h21, 8'h22, 8'h23});
	endtask
	task t_rd_wr();
		m.issue(RD, 12'h030, 16'h0, 1);
		m.issue(WR, 12'h040, 16'h1000, 3);
		wst(ST_WREC);
		wst(ST_ACTIVE);
		rdq('{8'h30, 8'h31});
		wrq('{24'h401000, 24'h411001, 24'h421002, 24'h431003});
		m.issue(WR, 12'h050, 16'h2000, 1);
		m.issue(RD, 12'h060, 16'h0, 6);
		wrq('{24'h502000, 24'h512001});
		rdq('{8'h60, 8'h61, 8'h62, 8'h63});
		m.issue(WR, 12'h070, 16'h3000, 1);
		m.issue(WR, 12'h078, 16'h4000, 6);
		wrq('{24'h703000, 24'h713001, 24'h784000, 24'h794001, 24'h7a4002, 24'h7b4003});
		m.issue(WR, 12'h080, 16'h5000, 1);
		m.issue(4'h6, 12'h0, 16'h0, 1);
		wst(ST_ACTIVE);
		wrq('{24'h805000, 24'h815001});
		m.issue(WR, 12'h090, 16'h6000, 1);
		m.issue(PRE, 12'h000, 16'h0, 0);
		wst(ST_PRECH);
		wst(ST_IDLE);
		wrq('{24'h906000, 24'h916001});
	endtask
	task t_pre_ap();
		m.issue(ACT, 12'h006, 16'h0, 2);
		m.issue(RD, 12'h0a0, 16'h0, 1);
		m.issue(PRE, 12'h400, 16'h0, 0);
		wst(ST_PRECH);
		wst(ST_IDLE);
		rdq('{8'ha0, 8'ha1});
		slow <= 1'b1;
		m.issue(ACT, 12'h007, 16'h0, 2);
		m.issue(RD, 12'h4c0, 16'h0, 0);
		wst(ST_READ_AP);
		wst(ST_PRECH);
		wst(ST_IDLE);
		rdq('{8'hc0, 8'hc1, 8'hc2, 8'hc3});
		slow <= 1'b0;
		m.issue(ACT, 12'h008, 16'h0, 2);
		m.issue(WR, 12'h4d0, 16'h7000, 3);
		wst(ST_WREC_AP);
		wst(ST_IDLE);
		wrq('{24'hd07000, 24'hd17001, 24'hd27002, 24'hd37003});
	endtask
	task end_of_test();
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		end_of_test();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (6) @(posedge clk);
		t_idle();
		t_read();
		t_rd_wr();
		t_pre_ap();
		end_of_test();
	end
endmodule
